// File: verilog/cioc_regs.svh
// constants for the configurable io cell: encodings, indices, reset values
`ifndef CIOC_REGS_SVH
`define CIOC_REGS_SVH

// shared set/reset modes, gray ordered
`define CIOC_SRM_SYNC_SET 2'h0
`define CIOC_SRM_SYNC_RST 2'h1
`define CIOC_SRM_ASYNC_CLR 2'h3
`define CIOC_SRM_ASYNC_PRE 2'h2

// storage element indices
`define CIOC_EL_IN 0
`define CIOC_EL_OUT 1
`define CIOC_EL_TS 2
`define CIOC_EL_NUM 3

// input delay stages matched to clock distribution
`define CIOC_IN_DLY_STAGES 1

// reset values
`define CIOC_STOR_RST 1'b0
`define CIOC_PAD_OE_RST 1'b0
`define CIOC_PAD_O_RST 1'b0
`define CIOC_PULL_RST 1'b0

`endif

// File: verilog/cioc_pkg.sv
// types shared by the configurable io cell modules
package cioc_pkg;
`include "cioc_regs.svh"

    // how the shared set/reset acts on one storage element
    typedef enum logic [1:0] {
        CIOC_SYNC_SET = `CIOC_SRM_SYNC_SET,
        CIOC_SYNC_RST = `CIOC_SRM_SYNC_RST,
        CIOC_ASYNC_CLR = `CIOC_SRM_ASYNC_CLR,
        CIOC_ASYNC_PRE = `CIOC_SRM_ASYNC_PRE
    } cioc_srmode_t;

    // true for the modes that ignore the cell clock
    function automatic logic cioc_is_async(input cioc_srmode_t m);
        return (m == CIOC_ASYNC_CLR) || (m == CIOC_ASYNC_PRE);
    endfunction

    // level that the set/reset forces
    function automatic logic cioc_sr_value(input cioc_srmode_t m);
        return (m == CIOC_SYNC_SET) || (m == CIOC_ASYNC_PRE);
    endfunction
endpackage

// File: verilog/cioc_stor_if.sv
// interface between the cell and one of its storage elements
interface cioc_stor_if;
    logic d; // data into the element
    logic ce; // effective clock enable
    logic sr; // effective shared set/reset
    logic clk_rise; // effective cell clock rising this cycle
    logic clk_high; // effective cell clock at active level
    logic latch; // element works as a transparent latch
    cioc_pkg::cioc_srmode_t mode; // set/reset mode
    logic q; // element output

    modport ctrl(output d, ce, sr, clk_rise, clk_high, latch, mode,
        input q);
    modport stor(input d, ce, sr, clk_rise, clk_high, latch, mode,
        output q);
endinterface

// File: verilog/cioc_stor.sv
// one storage element of the io cell: flip-flop or latch
`include "cioc_regs.svh"
module cioc_stor (
    input wire logic mclk,
    input wire logic rst_b,
    cioc_stor_if.stor s
);
    logic q_q; // stored value
    logic q_d; // next stored value
    logic evt; // clock event for the chosen mode

    // next value of the element
    always_comb begin
        q_d = q_q;
        evt = s.latch ? s.clk_high : s.clk_rise;
        if (cioc_pkg::cioc_is_async(s.mode) && s.sr) begin
            q_d = cioc_pkg::cioc_sr_value(s.mode);
        end else if (evt) begin
            if (s.sr && !cioc_pkg::cioc_is_async(s.mode)) begin
                q_d = cioc_pkg::cioc_sr_value(s.mode);
            end else if (s.ce) begin
                q_d = s.d;
            end
        end
    end

    // register the element
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            q_q <= `CIOC_STOR_RST;
        end else begin
            q_q <= q_d;
        end
    end

    assign s.q = q_q;

    property p_async_sr;
        @(posedge mclk) disable iff (!rst_b)
        cioc_pkg::cioc_is_async(s.mode) && s.sr |=>
            q_q == cioc_pkg::cioc_sr_value($past(s.mode));
    endproperty
    a_async_sr: assert property (p_async_sr)
        else $error("async set/reset not applied");

    property p_ce_hold;
        @(posedge mclk) disable iff (!rst_b)
        !s.ce && !s.sr |=> $stable(q_q);
    endproperty
    a_ce_hold: assert property (p_ce_hold)
        else $error("element changed with enable low");

    property p_latch_pass;
        @(posedge mclk) disable iff (!rst_b)
        s.latch && s.clk_high && s.ce && !s.sr |=> q_q == $past(s.d);
    endproperty
    a_latch_pass: assert property (p_latch_pass)
        else $error("transparent latch did not pass data");

    property p_ff_no_edge;
        @(posedge mclk) disable iff (!rst_b)
        !s.latch && !s.clk_rise && !s.sr |=> $stable(q_q);
    endproperty
    a_ff_no_edge: assert property (p_ff_no_edge)
        else $error("flip-flop changed without clock edge");
endmodule

// File: verilog/cioc_io_cell.sv
// configurable io cell: pad paths, storage elements, pulls, keeper, scan
// How it works
// - each element is flip-flop or latch
// - one cell clock, enable per element
// - shared set/reset, mode chosen per element
// - data and control signals invert independently
// - unconfigured: pad driver always high impedance
// - unconfigured: no pull-down, no keeper
// - unconfigured pull-up from global mode pins
// - pad value direct and via input element
// - optional matched delay before input element
// - pad data from logic or element
// - enable from logic or enable element
// - keeper senses pad, drives same level
// - configured pull-up and pull-down selectable
// - boundary scan observes and controls pad
`include "cioc_regs.svh"
module cioc_io_cell #(
    parameter int unsigned IN_DLY = `CIOC_IN_DLY_STAGES
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic cfg_done, // device configured
    input wire logic cfg_pullup_mode, // global pre-config pull-up
    input wire logic cell_clk, // common cell clock
    input wire logic [2:0] ce, // enables: ts, out, in
    input wire logic shared_set_reset,
    input wire logic [2:0] latch_sel, // element is latch
    input wire logic [2:0][1:0] sr_mode, // per element mode
    input wire logic inv_in,
    input wire logic inv_out,
    input wire logic inv_ts,
    input wire logic inv_clk,
    input wire logic [2:0] inv_ce,
    input wire logic inv_sr,
    input wire logic in_dly_sel, // delay before input element
    input wire logic out_reg_sel, // pad data from element
    input wire logic ts_reg_sel, // enable from element
    input wire logic keeper_sel,
    input wire logic pullup_sel,
    input wire logic pulldown_sel,
    input wire logic core_o, // data from internal logic
    input wire logic core_oe, // enable from internal logic
    input wire logic pad_i,
    output logic pad_o,
    output logic pad_oe,
    output logic in_direct, // unstored input path
    output logic in_reg, // input element output
    output logic pullup_en,
    output logic pulldown_en,
    output logic keeper_en,
    output logic keeper_lvl, // level the keeper holds
    input wire logic bs_extest, // scan owns the pad
    input wire logic bs_drv,
    input wire logic bs_drv_oe,
    output logic bs_capture // pad level seen by scan
);
    cioc_stor_if sif[`CIOC_EL_NUM] (); // one per element

    logic clk_lvl_q, clk_lvl_d; // effective clock last cycle
    logic eff_clk; // clock after inversion
    logic in_val; // pad after input inversion
    logic [IN_DLY-1:0] dly_q, dly_d; // matched delay line
    logic in_q, in_d; // direct input path
    logic [2:0] d_vec; // element data inputs
    logic [2:0] q_vec; // element outputs
    logic pad_o_q, pad_o_d;
    logic pad_oe_q, pad_oe_d;
    logic pu_q, pu_d;
    logic pd_q, pd_d;
    logic kp_q, kp_d;
    logic kl_q, kl_d;
    logic bs_q, bs_d;
    logic out_src; // data toward the driver
    logic oe_src; // enable toward the driver

    assign eff_clk = cell_clk ^ inv_clk;
    assign in_val = pad_i ^ inv_in;

    // element data: optional delayed pad into input element
    always_comb begin
        d_vec = '0;
        d_vec[`CIOC_EL_IN] = in_dly_sel ? dly_q[IN_DLY-1] : in_val;
        d_vec[`CIOC_EL_OUT] = core_o;
        d_vec[`CIOC_EL_TS] = core_oe;
    end

    // connect the three elements
    genvar g;
    generate
        for (g = 0; g < `CIOC_EL_NUM; g++) begin : g_el
            assign sif[g].clk_rise = eff_clk & ~clk_lvl_q;
            assign sif[g].clk_high = eff_clk;
            assign sif[g].ce = ce[g] ^ inv_ce[g];
            assign sif[g].sr = shared_set_reset ^ inv_sr;
            assign sif[g].latch = latch_sel[g];
            assign sif[g].mode = cioc_pkg::cioc_srmode_t'(sr_mode[g]);
            assign sif[g].d = d_vec[g];
            assign q_vec[g] = sif[g].q;
            cioc_stor u_stor (
                .mclk(mclk),
                .rst_b(rst_b),
                .s(sif[g])
            );
        end
    endgenerate

    // next values of the pad side
    always_comb begin
        clk_lvl_d = eff_clk;
        dly_d[0] = in_val;
        for (int i = 1; i < IN_DLY; i++) begin
            dly_d[i] = dly_q[i-1];
        end
        in_d = in_val;
        out_src = out_reg_sel ? q_vec[`CIOC_EL_OUT] : core_o;
        oe_src = (ts_reg_sel ? q_vec[`CIOC_EL_TS] : core_oe) ^ inv_ts;
        pad_o_d = out_src ^ inv_out;
        pad_oe_d = oe_src;
        if (bs_extest) begin
            pad_o_d = bs_drv;
            pad_oe_d = bs_drv_oe;
        end
        if (!cfg_done) begin
            pad_oe_d = 1'b0;
        end
        // global pull-up before, own select after
        pu_d = cfg_done ? pullup_sel : cfg_pullup_mode;
        // pull-down and keeper off until configured
        pd_d = cfg_done & pulldown_sel;
        kp_d = cfg_done & keeper_sel;
        // keeper follows the raw pad level
        kl_d = pad_i;
        // pad stays observable when not driven
        bs_d = pad_i;
    end

    // register the pad side
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            clk_lvl_q <= 1'b0;
            dly_q <= '0;
            in_q <= 1'b0;
            pad_o_q <= `CIOC_PAD_O_RST;
            pad_oe_q <= `CIOC_PAD_OE_RST;
            pu_q <= `CIOC_PULL_RST;
            pd_q <= `CIOC_PULL_RST;
            kp_q <= 1'b0;
            kl_q <= 1'b0;
            bs_q <= 1'b0;
        end else begin
            clk_lvl_q <= clk_lvl_d;
            dly_q <= dly_d;
            in_q <= in_d;
            pad_o_q <= pad_o_d;
            pad_oe_q <= pad_oe_d;
            pu_q <= pu_d;
            pd_q <= pd_d;
            kp_q <= kp_d;
            kl_q <= kl_d;
            bs_q <= bs_d;
        end
    end

    // outputs straight from flops
    assign pad_o = pad_o_q;
    assign pad_oe = pad_oe_q;
    assign in_direct = in_q;
    assign in_reg = q_vec[`CIOC_EL_IN];
    assign pullup_en = pu_q;
    assign pulldown_en = pd_q;
    assign keeper_en = kp_q;
    assign keeper_lvl = kl_q;
    assign bs_capture = bs_q;

    property p_unconf_hiz;
        @(posedge mclk) disable iff (!rst_b)
        !cfg_done |=> !pad_oe_q;
    endproperty
    a_unconf_hiz: assert property (p_unconf_hiz)
        else $error("pad driven before configuration");

    property p_unconf_pulls;
        @(posedge mclk) disable iff (!rst_b)
        !cfg_done |=> !pd_q && !kp_q;
    endproperty
    a_unconf_pulls: assert property (p_unconf_pulls)
        else $error("pull-down or keeper on before configuration");

    property p_global_pu;
        @(posedge mclk) disable iff (!rst_b)
        !cfg_done |=> pu_q == $past(cfg_pullup_mode);
    endproperty
    a_global_pu: assert property (p_global_pu)
        else $error("pre-config pull-up ignores mode pins");

    property p_direct_in;
        @(posedge mclk) disable iff (!rst_b)
        1'b1 ##1 1'b1 |-> in_q == $past(pad_i ^ inv_in);
    endproperty
    a_direct_in: assert property (p_direct_in)
        else $error("direct input path wrong");

    property p_out_direct;
        @(posedge mclk) disable iff (!rst_b)
        !bs_extest && !out_reg_sel |=> pad_o_q == $past(core_o ^ inv_out);
    endproperty
    a_out_direct: assert property (p_out_direct)
        else $error("direct output data wrong");

    property p_oe_direct;
        @(posedge mclk) disable iff (!rst_b)
        cfg_done && !bs_extest && !ts_reg_sel |=>
            pad_oe_q == $past(core_oe ^ inv_ts);
    endproperty
    a_oe_direct: assert property (p_oe_direct)
        else $error("direct enable wrong");

    property p_keeper;
        @(posedge mclk) disable iff (!rst_b)
        cfg_done && keeper_sel |=> kp_q && kl_q == $past(pad_i);
    endproperty
    a_keeper: assert property (p_keeper)
        else $error("keeper not following pad");

    property p_scan;
        @(posedge mclk) disable iff (!rst_b)
        cfg_done && bs_extest |=> pad_o_q == $past(bs_drv) &&
            pad_oe_q == $past(bs_drv_oe) && bs_q == $past(pad_i);
    endproperty
    a_scan: assert property (p_scan)
        else $error("scan control of pad wrong");

    property p_pulls_cfg;
        @(posedge mclk) disable iff (!rst_b)
        cfg_done |=> pu_q == $past(pullup_sel) &&
            pd_q == $past(pulldown_sel);
    endproperty
    a_pulls_cfg: assert property (p_pulls_cfg)
        else $error("configured pulls not as selected");
endmodule

// File: test/cioc_pad_model.sv
// board side of one pad: external driver, pulls, keeper, floating line
module cioc_pad_model (
    input wire logic mclk,
    input wire logic pad_o,
    input wire logic pad_oe,
    input wire logic pullup_en,
    input wire logic pulldown_en,
    input wire logic keeper_en,
    input wire logic keeper_lvl,
    input wire logic ext_en, // board driver active
    input wire logic ext_val, // board driver level
    output logic pad_i
);
    timeunit 1ns;
    timeprecision 1ps;
    logic flt_q = 1'b0; // level of an undriven pad

    // a floating pad wanders every cycle, never a stable guess
    always @(posedge mclk) begin
        flt_q <= ~flt_q;
    end

    // resolve the pad from every party, strongest first
    always_comb begin
        if (pad_oe && ext_en) begin
            pad_i = 1'bx; // two drivers fighting
        end else if (pad_oe) begin
            pad_i = pad_o;
        end else if (ext_en) begin
            pad_i = ext_val;
        end else if (pullup_en && !pulldown_en) begin
            pad_i = 1'b1;
        end else if (pulldown_en && !pullup_en) begin
            pad_i = 1'b0;
        end else if (keeper_en) begin
            pad_i = keeper_lvl; // weak hold of last level
        end else begin
            pad_i = flt_q;
        end
    end
endmodule

// File: test/tb_cioc_io_cell.sv
// self-checking bench for the configurable io cell
module tb_cioc_io_cell;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned IN_DLY = 1; // matched delay length
    logic mclk = 1'b0;
    logic rst_b, cfg_done, cfg_pullup_mode, cell_clk, shared_set_reset;
    logic [2:0] ce, latch_sel, inv_ce;
    logic [2:0][1:0] sr_mode;
    logic inv_in, inv_out, inv_ts, inv_clk, inv_sr, in_dly_sel;
    logic out_reg_sel, ts_reg_sel, keeper_sel, pullup_sel, pulldown_sel;
    logic core_o, core_oe, pad_i, bs_extest, bs_drv, bs_drv_oe;
    logic pad_o, pad_oe, in_direct, in_reg, pullup_en, pulldown_en;
    logic keeper_en, keeper_lvl, bs_capture, ext_en, ext_val;
    logic v; // level a set/reset mode forces
    int n_fail = 0;
    int tests_run = 0;
    int m;

    cioc_io_cell #(.IN_DLY(IN_DLY)) cioc_io_cell_i (.*);
    cioc_pad_model cioc_pad_model_i (.*);

    // 250 MHz clock
    always #2 mclk = ~mclk;

    // wait n falling edges, where inputs change
    task automatic tick(input int n);
        repeat (n) @(negedge mclk);
    endtask

    // compare one output with its expected level
    task automatic chk(input logic seen, input logic exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: seen %h expected %h",
                $time, seen, exp);
        end
    endtask

    // one cell clock pulse, outputs settled afterwards
    task automatic pulse();
        cell_clk = 1'b1;
        tick(3);
        cell_clk = 1'b0;
        tick(3);
    endtask

    // verdict and end of run
    task automatic test_done();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // watchdog against a hang
    initial begin
        #20000;
        n_fail++;
        test_done();
    end

    // main sequence
    initial begin
        {rst_b, cfg_done, cfg_pullup_mode, cell_clk, shared_set_reset} = '0;
        {ce, latch_sel, inv_ce, sr_mode} = '0;
        {inv_in, inv_out, inv_ts, inv_clk, inv_sr, in_dly_sel} = '0;
        {out_reg_sel, ts_reg_sel, keeper_sel, pullup_sel, pulldown_sel} = '0;
        {core_o, core_oe, bs_extest, bs_drv, bs_drv_oe, ext_en, ext_val} = '0;
        tick(5);
        chk(pad_oe, 1'b0);
        rst_b = 1'b1;
        // unconfigured: driver off even under scan, pull-down and keeper off, pull-up from mode pins
        {core_oe, core_o, pulldown_sel, keeper_sel} = 4'hf;
        {bs_extest, bs_drv_oe, cfg_pullup_mode} = 3'h7;
        tick(3);
        chk(pad_oe, 1'b0);
        chk(pulldown_en, 1'b0);
        chk(keeper_en, 1'b0);
        chk(pullup_en, 1'b1);
        chk(in_direct, 1'b1);
        cfg_pullup_mode = 1'b0;
        tick(2);
        chk(pullup_en, 1'b0);
        // configured: scan drives and observes the pad
        {cfg_done, bs_drv, inv_out} = 3'h7;
        tick(3);
        chk(pad_o, 1'b1);
        chk(pad_oe, 1'b1);
        chk(bs_capture, 1'b1);
        chk(pulldown_en, 1'b1);
        chk(keeper_en, 1'b1);
        // direct output paths with polarity
        {bs_extest, pulldown_sel} = 2'h0;
        tick(3);
        chk(pad_o, 1'b0);
        chk(pad_oe, 1'b1);
        inv_ts = 1'b1;
        tick(3);
        chk(pad_oe, 1'b0);
        // keeper holds what the board last drove
        {ext_en, ext_val} = 2'h3;
        tick(2);
        ext_en = 1'b0;
        tick(4);
        chk(in_direct, 1'b1);
        chk(keeper_lvl, 1'b1);
        inv_in = 1'b1;
        tick(2);
        chk(in_direct, 1'b0);
        {inv_in, keeper_sel, pullup_sel} = 3'h1;
        tick(3);
        chk(pullup_en, 1'b1);
        chk(in_direct, 1'b1);
        chk(keeper_en, 1'b0);
        pullup_sel = 1'b0;
        // output element as flip-flop: rising event only
        {out_reg_sel, ce, inv_out, core_o} = {1'b1, 3'h2, 1'b0, 1'b1};
        pulse();
        chk(pad_o, 1'b1);
        cell_clk = 1'b1;
        tick(2);
        core_o = 1'b0;
        tick(3);
        chk(pad_o, 1'b1);
        {cell_clk, ce} = 4'h0;
        tick(2);
        pulse();
        chk(pad_o, 1'b1);
        inv_ce[1] = 1'b1;
        pulse();
        chk(pad_o, 1'b0);
        // latch: follows while clock high, holds when low
        {inv_ce, ce, latch_sel, core_o} = {3'h0, 3'h2, 3'h2, 1'b1};
        cell_clk = 1'b1;
        tick(3);
        chk(pad_o, 1'b1);
        core_o = 1'b0;
        tick(3);
        chk(pad_o, 1'b0);
        cell_clk = 1'b0;
        tick(2);
        core_o = 1'b1;
        tick(3);
        chk(pad_o, 1'b0);
        // inverting the clock makes a low clock an event
        {latch_sel, inv_clk} = 4'h1;
        tick(3);
        chk(pad_o, 1'b1);
        inv_clk = 1'b0;
        // let the low clock be seen so the next pulse is a rise
        tick(1);
        // every set/reset mode, with and without a clock event
        for (m = 0; m < 4; m++) begin
            sr_mode[1] = m[1:0];
            v = (m == 0) || (m == 2);
            core_o = ~v;
            pulse();
            shared_set_reset = 1'b1;
            tick(3);
            chk(pad_o, (m >= 2) ? v : ~v);
            pulse();
            chk(pad_o, v);
            shared_set_reset = 1'b0;
        end
        core_o = 1'b1;
        pulse();
        inv_sr = 1'b1;
        tick(3);
        chk(pad_o, 1'b0);
        inv_sr = 1'b0;
        // registered enable changes only on a clock event
        {ts_reg_sel, inv_ts, ce, core_oe} = {1'b1, 1'b0, 3'h4, 1'b1};
        pulse();
        chk(pad_oe, 1'b1);
        core_oe = 1'b0;
        tick(3);
        chk(pad_oe, 1'b1);
        pulse();
        chk(pad_oe, 1'b0);
        // input element, then matched delay keeps the older value
        {ce, ext_en, ext_val} = {3'h1, 1'b1, 1'b0};
        tick(2);
        pulse();
        chk(in_reg, 1'b0);
        {ext_val, in_dly_sel} = 2'h3;
        tick(3);
        {ext_val, cell_clk} = 2'h1;
        tick(3);
        chk(in_reg, 1'b1);
        cell_clk = 1'b0;
        tick(2);
        test_done();
    end
endmodule
